// *** rtl/bdsb_core.sv ***
/*
 * Debug status/control register and 16-bit breakpoint match register,
 * with the breakpoint request logic that they steer.
 * Assumes a serial command decoder delivering one-cycle command strobes
 * and a CPU reporting its mode, fetch address and memory command result.
 */
`timescale 1ns/10ps
`include "bdsb_defs.svh"

// How it works
// - Control register reached only through serial commands.
// - Permit bit sticks until normal reset.
// - Active bit reads background mode, read only.
// - Breakpoint disabled ignores select and address.
// - Tag marks fetch; force stops at boundary.
// - Clock select bit, zero means alternate.
// - Wait/stop status bit reports wait or stop.
// - Wait/stop drops reads and flags all commands; writes still land.
// - Force command in wait/stop wakes CPU into background.
// - Fail flag set on wait/stop collision.
// - Slow access fail bit always zero.
// - Breakpoint address via serial commands only.
// - Permit unwritable in background; status never written.
// - Unpermitted breakpoint becomes software interrupt.

module bdsb_core
	import bdsb_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Serial command side
	input  wire bdsb_cmd_s   i_cmd,
	output logic [15:0]      o_rdata,
	output logic             o_rvalid,
	output logic             o_cmd_blocked,
	// CPU side
	input  wire bdsb_cpu_s   i_cpu,
	output logic             o_tag_req,
	output logic             o_force_req,
	output logic             o_soft_int_req,
	output logic             o_wake_to_bg,
	output logic             o_comm_clock_select
);

	// ****************************************
	// Registers
	// ****************************************
	logic        background_permit;
	logic        breakpoint_enable;
	logic        force_tag_select;
	logic        wait_stop_status;
	logic        wait_stop_fail;
	logic        bg_prev;
	logic [15:0] debug_breakpoint_address;
	logic [7:0]  debug_status_control;
	logic        match;
	logic        cmd_any;
	bdsb_mode_e  mode;

	// Permit bit only sets by command; clears on reset only.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			background_permit <= 1'b0;
		end else if (i_cmd.wr_control && !i_cpu.in_background &&
			i_cmd.wdata[`BDSB_BIT_PERMIT]) begin
			background_permit <= 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			breakpoint_enable   <= 1'b0;
			force_tag_select    <= 1'b0;
			o_comm_clock_select <= 1'b0;
		end else if (i_cmd.wr_control) begin
			breakpoint_enable   <= i_cmd.wdata[`BDSB_BIT_BKEN];
			force_tag_select    <= i_cmd.wdata[`BDSB_BIT_FORCE];
			o_comm_clock_select <= i_cmd.wdata[`BDSB_BIT_CLKSEL];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			debug_breakpoint_address <= `BDSB_BKPT_RESET;
		end else if (i_cmd.wr_bkpt) begin
			debug_breakpoint_address <= i_cmd.wdata;
		end
	end

	// ****************************************
	// CPU mode tracking
	// ****************************************
	// Wait/stop status holds through a forced wake into background.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode <= BDSB_RUN;
		end else begin
			case (mode)
			BDSB_RUN: begin
				if (i_cpu.in_wait_stop)
					mode <= BDSB_WAITSTOP;
				else if (i_cpu.in_background)
					mode <= BDSB_BG;
			end
			BDSB_WAITSTOP: begin
				if (!i_cpu.in_wait_stop && !i_cpu.in_background)
					mode <= BDSB_RUN;
			end
			BDSB_BG: begin
				if (!i_cpu.in_background)
					mode <= BDSB_RUN;
			end
			default: mode <= BDSB_RUN;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wait_stop_status <= 1'b0;
		end else begin
			wait_stop_status <= i_cpu.in_wait_stop ||
				(mode == BDSB_WAITSTOP && i_cpu.in_background);
		end
	end

	// Background level one cycle back, to spot the exit from background.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bg_prev <= 1'b0;
		end else begin
			bg_prev <= i_cpu.in_background;
		end
	end

	// Failure flag clears when the CPU leaves background; set wins.
	// The exit is seen from the level itself, so a background entered
	// from wait/stop clears the flag on its way out as well.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wait_stop_fail <= 1'b0;
		end else if (i_cpu.mem_cmd_fail_wait) begin
			wait_stop_fail <= 1'b1;
		end else if (bg_prev && !i_cpu.in_background) begin
			wait_stop_fail <= 1'b0;
		end
	end

	// ****************************************
	// Command gating and wake
	// ****************************************
	assign cmd_any = i_cmd.rd_status | i_cmd.wr_control |
		i_cmd.rd_bkpt | i_cmd.wr_bkpt;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cmd_blocked <= 1'b0;
			o_wake_to_bg  <= 1'b0;
		end else begin
			o_cmd_blocked <= i_cpu.in_wait_stop && cmd_any;
			o_wake_to_bg  <= i_cpu.force_bg_cmd && i_cpu.in_wait_stop;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		debug_status_control = `BDSB_CTRL_RESET;
		debug_status_control[`BDSB_BIT_PERMIT] = background_permit;
		debug_status_control[`BDSB_BIT_ACTIVE] = i_cpu.in_background;
		debug_status_control[`BDSB_BIT_BKEN]   = breakpoint_enable;
		debug_status_control[`BDSB_BIT_FORCE]  = force_tag_select;
		debug_status_control[`BDSB_BIT_CLKSEL] = o_comm_clock_select;
		debug_status_control[`BDSB_BIT_WAIT]   = wait_stop_status;
		debug_status_control[`BDSB_BIT_WFAIL]  = wait_stop_fail;
		debug_status_control[`BDSB_BIT_SAF]    = 1'b0;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata  <= 16'h0000;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= (i_cmd.rd_status || i_cmd.rd_bkpt) &&
				!i_cpu.in_wait_stop;
			if (i_cmd.rd_status)
				o_rdata <= {8'h00, debug_status_control};
			else if (i_cmd.rd_bkpt)
				o_rdata <= debug_breakpoint_address;
		end
	end

	// ****************************************
	// Breakpoint request
	// ****************************************
	assign match = breakpoint_enable && i_cpu.fetch_valid &&
		!i_cpu.in_background &&
		(i_cpu.addr == debug_breakpoint_address);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_tag_req      <= 1'b0;
			o_force_req    <= 1'b0;
			o_soft_int_req <= 1'b0;
		end else begin
			o_tag_req      <= match && background_permit &&
				!force_tag_select;
			o_force_req    <= match && background_permit &&
				force_tag_select;
			o_soft_int_req <= match && !background_permit;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	permit_sticks_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		$past(background_permit) |-> background_permit)
		else $error("permit bit cleared without reset");
	permit_bg_lock_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(i_cpu.in_background && !background_permit) |=>
		!background_permit)
		else $error("permit set while in background");
	active_bit_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_cmd.rd_status |=> o_rdata[`BDSB_BIT_ACTIVE] ==
		$past(i_cpu.in_background))
		else $error("active bit wrong");
	bp_disabled_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!breakpoint_enable |=> !o_tag_req && !o_force_req &&
		!o_soft_int_req)
		else $error("breakpoint fired while disabled");
	force_kind_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_force_req |-> $past(force_tag_select) && !o_tag_req)
		else $error("force request with tag select");
	soft_int_path_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(match && !background_permit) |=>
		o_soft_int_req && !o_force_req)
		else $error("unpermitted break not soft interrupt");
	saf_zero_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_rvalid && $past(i_cmd.rd_status) |-> !o_rdata[`BDSB_BIT_SAF])
		else $error("slow access flag set");
	wait_fail_set_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_cpu.mem_cmd_fail_wait |=> wait_stop_fail)
		else $error("wait stop fail not set");
	wait_fail_clear_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(bg_prev && !i_cpu.in_background && !i_cpu.mem_cmd_fail_wait)
		|=> !wait_stop_fail)
		else $error("wait stop fail kept after leaving background");
	wait_block_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(i_cpu.in_wait_stop && cmd_any) |=>
		o_cmd_blocked && !o_rvalid)
		else $error("command not blocked in wait stop");
	wake_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(i_cpu.force_bg_cmd && i_cpu.in_wait_stop) |=> o_wake_to_bg)
		else $error("force command did not wake");

endmodule

// *** common/bdsb_defs.svh ***
/*
 * Constants for the debug status/control and breakpoint block.
 * Assumes inclusion by bare name from design files.
 */
`ifndef BDSB_DEFS_SVH
`define BDSB_DEFS_SVH

// ****************************************
// Status/control bit positions
// ****************************************
`define BDSB_BIT_PERMIT   7
`define BDSB_BIT_ACTIVE   6
`define BDSB_BIT_BKEN     5
`define BDSB_BIT_FORCE    4
`define BDSB_BIT_CLKSEL   3
`define BDSB_BIT_WAIT     2
`define BDSB_BIT_WFAIL    1
`define BDSB_BIT_SAF      0

// ****************************************
// Reset values
// ****************************************
`define BDSB_CTRL_RESET   8'h00
`define BDSB_BKPT_RESET   16'h0000

`endif

// *** common/bdsb_pkg.sv ***
/*
 * Types for the debug status/control and breakpoint block.
 * Assumes nothing of its surroundings.
 */
package bdsb_pkg;

	// Command strobes from the serial command decoder.
	typedef struct packed {
		logic        rd_status;
		logic        wr_control;
		logic        rd_bkpt;
		logic        wr_bkpt;
		logic [15:0] wdata;
	} bdsb_cmd_s;

	// CPU status as seen by the debug controller.
	typedef struct packed {
		logic        in_background;
		logic        in_wait_stop;
		logic        fetch_valid;
		logic [15:0] addr;
		logic        mem_cmd_fail_wait;
		logic        force_bg_cmd;
	} bdsb_cpu_s;

	typedef enum logic [1:0] {
		BDSB_RUN,
		BDSB_WAITSTOP,
		BDSB_BG
	} bdsb_mode_e;

endpackage

// *** bench/bdsb_host.sv ***
/*
 * Debug host model that issues serial command strobes.
 * Assumes the block samples commands on rising edges.
 */
`timescale 1ns/10ps
module bdsb_host
	import bdsb_pkg::*;
(
	// Clock
	input  wire logic        i_clk,
	// Command side
	output bdsb_cmd_s        o_cmd,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_rvalid
);
	initial o_cmd = '0;

	// Released data is inverted so stale values never look valid.
	task automatic send(input logic [3:0] k, input logic [15:0] d);
		@(negedge i_clk);
		o_cmd = {k, d};
		@(negedge i_clk);
		o_cmd = {4'h0, ~d};
	endtask

	task automatic rd(input logic bk, output logic v, output logic [15:0] d);
		send(bk ? 4'h2 : 4'h8, 16'h0000);
		v = i_rvalid;
		d = i_rdata;
	endtask
endmodule

// *** bench/tb_top.sv ***
/*
 * Self-checking bench for the debug status and breakpoint block.
 * Assumes the host model and the design package.
 */
`timescale 1ns/10ps
module tb_top
	import bdsb_pkg::*;
;
	logic        clk;
	logic        rst;
	logic        v;
	logic        f;
	logic        t;
	logic        s;
	logic        w;
	logic        b;
	logic        cs;
	logic        rv;
	logic [15:0] rd;
	logic [15:0] bk;
	logic [15:0] d;
	bdsb_cmd_s   cmd;
	bdsb_cpu_s   cpu;
	int          n_errors;
	int          checked;
	int          cyc;
	integer      seed;

	bdsb_host i_host (.i_clk(clk), .o_cmd(cmd), .i_rdata(rd),
		.i_rvalid(rv));
	bdsb_core i_bdsb_core (.i_clk(clk), .i_rst(rst), .i_cmd(cmd),
		.o_rdata(rd), .o_rvalid(rv), .o_cmd_blocked(b), .i_cpu(cpu),
		.o_tag_req(t), .o_force_req(f), .o_soft_int_req(s),
		.o_wake_to_bg(w), .o_comm_clock_select(cs));

	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end

	task automatic report_and_stop;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk16(input string n, input logic [15:0] e, g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, g);
		chk16(n, {15'h0, e}, {15'h0, g});
	endtask

	function automatic logic [15:0] sts(input logic [7:0] c,
		input logic a, wt, wf);
		return {8'h00, c[7], a, c[5:3], wt, wf, 1'b0};
	endfunction

	// Expected request order is tag, force, software interrupt.
	task automatic fetch(input logic [15:0] a, input logic [2:0] e);
		@(negedge clk);
		cpu.fetch_valid = 1;
		cpu.addr = a;
		@(negedge clk);
		cpu.fetch_valid = 0;
		chk16("brk", {13'h0, e}, {13'h0, t, f, s});
	endtask

	task automatic pulse(input logic fl, fo);
		@(negedge clk);
		cpu.mem_cmd_fail_wait = fl;
		cpu.force_bg_cmd = fo;
		@(negedge clk);
		cpu.mem_cmd_fail_wait = 0;
		cpu.force_bg_cmd = 0;
		chk1("wake", fo, w);
	endtask

	task automatic ctl(input logic [7:0] wd, input logic [7:0] e);
		i_host.send(4'h4, {8'h00, wd});
		i_host.rd(0, v, d);
		chk16("sts", sts(e, 0, 0, 0), d);
		chk1("clk", e[3], cs);
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			report_and_stop();
		end
	end

	initial begin
		seed = 32'hdd745e6f;
		cpu = '0;
		rst = 1;
		repeat (12) @(posedge clk);
		@(negedge clk) rst = 0;
		i_host.rd(0, v, d);
		chk16("sts0", 16'h0000, d);
		chk1("rv", 1, v);
		i_host.rd(1, v, d);
		chk16("bk0", 16'h0000, d);
		chk1("clk0", 0, cs);
		bk = 16'($random(seed));
		i_host.send(4'h1, bk);
		ctl(8'h77, 8'h30);
		fetch(bk, 3'b001);
		ctl(8'hE8, 8'hA8);
		fetch(bk, 3'b100);
		ctl(8'h18, 8'h98);
		fetch(bk, 3'b000);
		ctl(8'h30, 8'hB0);
		fetch(bk, 3'b010);
		repeat (4) fetch(bk ^ (16'h1 << ($random(seed) & 15)), 3'b000);
		i_host.rd(1, v, d);
		chk16("bk", bk, d);
		@(negedge clk) cpu.in_wait_stop = 1;
		i_host.rd(0, v, d);
		chk1("rv_wait", 0, v);
		chk1("blk", 1, b);
		pulse(1, 0);
		pulse(0, 1);
		@(negedge clk);
		cpu.in_wait_stop = 0;
		cpu.in_background = 1;
		i_host.rd(0, v, d);
		chk16("sts_bg", sts(8'hB0, 1, 1, 1), d);
		i_host.send(4'h4, 16'h0000);
		i_host.rd(0, v, d);
		chk16("sts_wr", 16'h00C6, d);
		@(negedge clk) cpu.in_background = 0;
		i_host.rd(0, v, d);
		chk16("sts_run", 16'h0080, d);
		@(negedge clk) rst = 1;
		@(negedge clk) rst = 0;
		cpu.in_background = 1;
		i_host.send(4'h4, 16'h00FF);
		i_host.rd(0, v, d);
		chk16("sts_rst", 16'h0078, d);
		chk1("clk_rst", 1, cs);
		i_host.rd(1, v, d);
		chk16("bk_rst", 16'h0000, d);
		@(negedge clk) cpu.in_background = 0;
		report_and_stop();
	end
endmodule
